// *** upg_pkg.sv ***
`default_nettype none
package upg_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IER = 8'h0C;
  localparam logic [7:0] OFS_ICR = 8'h10;
  localparam logic [7:0] OFS_BAUD = 8'h14;
  localparam logic [7:0] OFS_TXD = 8'h18;
  localparam logic [7:0] OFS_RXD = 8'h1C;
  // control bits
  localparam int CTRL_CLR_STS_BIT = 0;
  // mode field position
  localparam int MODE_PAR_LSB = 0;
  // status bit positions
  localparam int ST_PERR_BIT = 0;
  localparam int ST_RXRDY_BIT = 1;
  localparam int ST_TXDONE_BIT = 2;
  localparam int ST_TXBUSY_BIT = 3;
  localparam int ST_ADDR_BIT = 4;
  localparam int ST_NUM = 3;
  // parity select encodings
  localparam logic [2:0] PAR_EVEN = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_SPACE = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_NONE = 3'h4;
  localparam logic [2:0] PAR_MULTI = 3'h6;
  // reset values
  localparam logic [2:0] MODE_RST = 3'h4;
  localparam logic [15:0] BAUD_RST = 16'h00D9;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
endpackage
`default_nettype wire

// *** upg_par_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface upg_par_if;
  logic [2:0] mode;
  logic [7:0] data;
  logic par_bit;
  logic has_par;
  logic rx_bit;
  logic rx_err;
  modport calc (input mode, input data, input rx_bit, output par_bit, output has_par,
    output rx_err);
  modport user (output mode, output data, output rx_bit, input par_bit, input has_par,
    input rx_err);
endinterface
`default_nettype wire

// *** upg_par_calc.sv ***
`timescale 1ns/1ps
`default_nettype none
module upg_par_calc (
  // parity request and result
  upg_par_if.calc p
);
  logic ones_odd;
  always_comb begin
    ones_odd = ^p.data;
    p.has_par = (p.mode != upg_pkg::PAR_NONE);
    unique case (p.mode)
      upg_pkg::PAR_EVEN: p.par_bit = ones_odd;
      upg_pkg::PAR_ODD: p.par_bit = ~ones_odd;
      upg_pkg::PAR_MARK: p.par_bit = 1'b1;
      upg_pkg::PAR_SPACE: p.par_bit = 1'b0;
      // multidrop: parity slot carries the address/data marker
      upg_pkg::PAR_MULTI: p.par_bit = 1'b0;
      default: p.par_bit = 1'b0;
    endcase
    // multidrop and none never flag; others compare sampled against expected
    p.rx_err = p.has_par && (p.mode != upg_pkg::PAR_MULTI) && (p.rx_bit != p.par_bit);
  end
endmodule
`default_nettype wire

// *** upg_top.sv ***
// Operation
// - Transmitter and receiver offer even, odd, mark, space and no parity via a mode field.
// - A further encoding of the parity field selects multidrop mode.
// - Even parity sends 0 for an even count of ones and 1 for odd; a mismatch is an error.
// - Odd parity sends 1 for an even count of ones and 0 for odd; a mismatch is an error.
// - Mark parity always sends 1 and a sampled 0 is an error.
// - Space parity always sends 0.
// - With no parity no bit is sent and no error is reported.
// - A detected parity error sets a sticky flag in the status register.
// - Writing the control register with the reset-status bit at 1 clears the flag.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module upg_top #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic rxd,
  output logic txd,
  // interrupt
  output logic irq
);
  localparam int ST_W = upg_pkg::ST_NUM;

  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} upg_phase_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [15:0] baud;
    logic [ST_W-1:0] ier;
    logic [ST_W-1:0] sts;
    logic [DATA_W-1:0] rx_data;
    logic rx_addr;
    logic [2:0] rx_sync;
    logic rx_line;
    upg_phase_t tx_ph;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [DATA_W-1:0] tx_sh;
    logic txd;
    upg_phase_t rx_ph;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [DATA_W-1:0] rx_sh;
    logic [31:0] rdata;
  } upg_state_t;

  upg_state_t r_ff, nxt_r;
  upg_par_if tx_p ();
  upg_par_if rx_p ();

  upg_par_calc u_tx_par (.p(tx_p.calc));
  upg_par_calc u_rx_par (.p(rx_p.calc));

  logic wr_en, rd_en;
  logic [ST_W-1:0] ev;
  logic rx_fall;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = r_ff.rdata;
  assign txd = r_ff.txd;
  assign irq = |(r_ff.sts & r_ff.ier);

  // only the agreed 2nd/3rd stages are looked at, never stage 0
  assign rx_fall = r_ff.rx_line && !r_ff.rx_sync[2] && !r_ff.rx_sync[1];

  always_comb begin
    tx_p.mode = r_ff.mode;
    tx_p.data = r_ff.tx_sh;
    tx_p.rx_bit = 1'b0;
    rx_p.mode = r_ff.mode;
    rx_p.data = r_ff.rx_sh;
    rx_p.rx_bit = r_ff.rx_line;
  end

  always_comb begin
    nxt_r = r_ff;
    ev = '0;
    nxt_r.rx_sync = {r_ff.rx_sync[1:0], rxd};
    if (r_ff.rx_sync[2] == r_ff.rx_sync[1]) begin
      nxt_r.rx_line = r_ff.rx_sync[2];
    end

    // transmitter; tx_sh kept unshifted until parity is out
    if (r_ff.tx_ph != S_IDLE) begin
      if (r_ff.tx_cnt == r_ff.baud) begin
        nxt_r.tx_cnt = '0;
        unique case (r_ff.tx_ph)
          S_START: begin
            nxt_r.tx_ph = S_DATA;
            nxt_r.txd = r_ff.tx_sh[0];
            nxt_r.tx_bit = 4'h1;
          end
          S_DATA: begin
            if (r_ff.tx_bit == 4'(DATA_W)) begin
              if (tx_p.has_par) begin
                nxt_r.tx_ph = S_PAR;
                nxt_r.txd = tx_p.par_bit;
              end else begin
                nxt_r.tx_ph = S_STOP;
                nxt_r.txd = 1'b1;
              end
            end else begin
              nxt_r.txd = r_ff.tx_sh[r_ff.tx_bit[2:0]];
              nxt_r.tx_bit = r_ff.tx_bit + 4'h1;
            end
          end
          S_PAR: begin
            nxt_r.tx_ph = S_STOP;
            nxt_r.txd = 1'b1;
          end
          S_STOP: begin
            nxt_r.tx_ph = S_IDLE;
            ev[upg_pkg::ST_TXDONE_BIT] = 1'b1;
          end
          default: nxt_r.tx_ph = S_IDLE;
        endcase
      end else begin
        nxt_r.tx_cnt = r_ff.tx_cnt + 16'h0001;
      end
    end

    // receiver: sample mid-bit
    unique case (r_ff.rx_ph)
      S_IDLE: begin
        if (rx_fall) begin
          nxt_r.rx_ph = S_START;
          nxt_r.rx_cnt = '0;
        end
      end
      default: begin
        if ((r_ff.rx_ph == S_START && r_ff.rx_cnt == {1'b0, r_ff.baud[15:1]}) ||
            (r_ff.rx_ph != S_START && r_ff.rx_cnt == r_ff.baud)) begin
          nxt_r.rx_cnt = '0;
          unique case (r_ff.rx_ph)
            S_START: begin
              nxt_r.rx_ph = r_ff.rx_line ? S_IDLE : S_DATA;
              nxt_r.rx_bit = '0;
            end
            S_DATA: begin
              nxt_r.rx_sh = {r_ff.rx_line, r_ff.rx_sh[DATA_W-1:1]};
              nxt_r.rx_bit = r_ff.rx_bit + 4'h1;
              if (r_ff.rx_bit == 4'(DATA_W - 1)) begin
                nxt_r.rx_ph = rx_p.has_par ? S_PAR : S_STOP;
              end
            end
            S_PAR: begin
              nxt_r.rx_ph = S_STOP;
              nxt_r.rx_addr = r_ff.rx_line;
              if (rx_p.rx_err) begin
                ev[upg_pkg::ST_PERR_BIT] = 1'b1;
              end
            end
            default: begin
              nxt_r.rx_ph = S_IDLE;
              nxt_r.rx_data = r_ff.rx_sh;
              ev[upg_pkg::ST_RXRDY_BIT] = 1'b1;
            end
          endcase
        end else begin
          nxt_r.rx_cnt = r_ff.rx_cnt + 16'h0001;
        end
      end
    endcase

    // register writes; hardware set wins over clear
    if (wr_en) begin
      unique case (paddr)
        upg_pkg::OFS_CTRL: begin
          if (pwdata[upg_pkg::CTRL_CLR_STS_BIT]) begin
            nxt_r.sts[upg_pkg::ST_PERR_BIT] = 1'b0;
          end
        end
        upg_pkg::OFS_MODE: nxt_r.mode = pwdata[upg_pkg::MODE_PAR_LSB +: 3];
        upg_pkg::OFS_IER: nxt_r.ier = pwdata[ST_W-1:0];
        upg_pkg::OFS_ICR: nxt_r.sts = r_ff.sts & ~pwdata[ST_W-1:0];
        upg_pkg::OFS_BAUD: nxt_r.baud = pwdata[15:0];
        upg_pkg::OFS_TXD: begin
          // a write while busy is dropped; software polls the busy bit
          if (r_ff.tx_ph == S_IDLE) begin
            nxt_r.tx_sh = pwdata[DATA_W-1:0];
            nxt_r.tx_ph = S_START;
            nxt_r.tx_cnt = '0;
            nxt_r.txd = 1'b0;
          end
        end
        default: ;
      endcase
    end
    nxt_r.sts = nxt_r.sts | ev;

    if (rd_en) begin
      unique case (paddr)
        upg_pkg::OFS_MODE: nxt_r.rdata = {29'h0, r_ff.mode};
        upg_pkg::OFS_STAT: nxt_r.rdata = {27'h0, r_ff.rx_addr, r_ff.tx_ph != S_IDLE,
          r_ff.sts};
        upg_pkg::OFS_IER: nxt_r.rdata = {29'h0, r_ff.ier};
        upg_pkg::OFS_BAUD: nxt_r.rdata = {16'h0, r_ff.baud};
        upg_pkg::OFS_RXD: nxt_r.rdata = {24'h0, r_ff.rx_data};
        default: nxt_r.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '{mode: upg_pkg::MODE_RST, baud: upg_pkg::BAUD_RST, ier: '0, sts: '0,
        rx_data: '0, rx_addr: 1'b0, rx_sync: 3'h7, rx_line: 1'b1, tx_ph: S_IDLE,
        tx_cnt: '0, tx_bit: '0, tx_sh: '0, txd: 1'b1, rx_ph: S_IDLE, rx_cnt: '0,
        rx_bit: '0, rx_sh: '0, rdata: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  a_perr_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    r_ff.sts[0] && !(wr_en && paddr == upg_pkg::OFS_CTRL && pwdata[0])
      && !(wr_en && paddr == upg_pkg::OFS_ICR && pwdata[0]) |=> r_ff.sts[0])
    else $error("parity error flag dropped without a clear");
  a_status_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_en && paddr == upg_pkg::OFS_CTRL && pwdata[0] && !ev[0] |=> !r_ff.sts[0])
    else $error("reset-status write left parity error set");
  a_none_no_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
    r_ff.mode == upg_pkg::PAR_NONE |-> !ev[0])
    else $error("parity error with parity off");
  a_mark_check: assert property (@(posedge sys_clk) disable iff (!rst_n)
    r_ff.rx_ph == S_PAR && r_ff.mode == upg_pkg::PAR_MARK && r_ff.rx_cnt == r_ff.baud
      |-> ev[0] == !r_ff.rx_line)
    else $error("mark parity check wrong");
  a_space_check: assert property (@(posedge sys_clk) disable iff (!rst_n)
    r_ff.rx_ph == S_PAR && r_ff.mode == upg_pkg::PAR_SPACE && r_ff.rx_cnt == r_ff.baud
      |-> ev[0] == r_ff.rx_line)
    else $error("space parity check wrong");
  a_even_tx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    r_ff.tx_ph == S_PAR && r_ff.mode == upg_pkg::PAR_EVEN |-> r_ff.txd == ^r_ff.tx_sh)
    else $error("even parity bit wrong");
  a_odd_tx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    r_ff.tx_ph == S_PAR && r_ff.mode == upg_pkg::PAR_ODD |-> r_ff.txd == ~^r_ff.tx_sh)
    else $error("odd parity bit wrong");
  a_par_place: assert property (@(posedge sys_clk) disable iff (!rst_n)
    r_ff.tx_ph == S_PAR |=> r_ff.tx_ph inside {S_PAR, S_STOP})
    else $error("parity not followed by stop");
  a_space_tx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    r_ff.tx_ph == S_PAR && r_ff.mode == upg_pkg::PAR_SPACE |-> !r_ff.txd)
    else $error("space parity bit not 0");
  a_mark_tx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    r_ff.tx_ph == S_PAR && r_ff.mode == upg_pkg::PAR_MARK |-> r_ff.txd)
    else $error("mark parity bit not 1");
  a_mode_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_en && paddr == upg_pkg::OFS_MODE
      |=> r_ff.mode == $past(pwdata[upg_pkg::MODE_PAR_LSB +: 3]))
    else $error("parity mode write lost");

  // frame steps the checks below are built from
  sequence s_tx_last_data;
    r_ff.tx_ph == S_DATA && r_ff.tx_cnt == r_ff.baud && r_ff.tx_bit == 4'(DATA_W);
  endsequence
  sequence s_rx_last_data;
    r_ff.rx_ph == S_DATA && r_ff.rx_cnt == r_ff.baud && r_ff.rx_bit == 4'(DATA_W - 1);
  endsequence
  sequence s_rx_par_slot;
    r_ff.rx_ph == S_PAR && r_ff.rx_cnt == r_ff.baud;
  endsequence

  a_tx_par_slot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_tx_last_data ##0 tx_p.has_par |=> r_ff.tx_ph == S_PAR)
    else $error("transmit parity slot skipped");
  a_tx_no_slot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_tx_last_data ##0 !tx_p.has_par |=> r_ff.tx_ph == S_STOP && r_ff.txd)
    else $error("parity slot sent with parity off");
  a_rx_par_slot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rx_last_data ##0 rx_p.has_par |=> r_ff.rx_ph == S_PAR)
    else $error("receive parity slot skipped");
  a_rx_no_slot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rx_last_data ##0 !rx_p.has_par |=> r_ff.rx_ph == S_STOP)
    else $error("receiver waited for a parity bit with parity off");
  a_rx_err_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rx_par_slot ##0 rx_p.rx_err |=> r_ff.sts[upg_pkg::ST_PERR_BIT])
    else $error("parity error not recorded");
  a_multi_no_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rx_par_slot ##0 r_ff.mode == upg_pkg::PAR_MULTI |-> !ev[upg_pkg::ST_PERR_BIT])
    else $error("parity error flagged in multidrop mode");
  a_even_rx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rx_par_slot ##0 r_ff.mode == upg_pkg::PAR_EVEN
      |-> ev[0] == (r_ff.rx_line != ^r_ff.rx_sh))
    else $error("even parity check wrong");
  a_odd_rx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rx_par_slot ##0 r_ff.mode == upg_pkg::PAR_ODD
      |-> ev[0] == (r_ff.rx_line == ^r_ff.rx_sh))
    else $error("odd parity check wrong");
endmodule
`default_nettype wire

// *** upg_remote.sv ***
`timescale 1ns/1ps
`default_nettype none
module upg_remote #(
  parameter int BIT_T = 4
) (
  // clock
  input wire logic sys_clk,
  // serial line
  input wire logic txd,
  output logic rxd
);
  // line rests high between frames, as a real idle line would
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] d, input logic hp, input logic pb);
    logic [10:0] f;
    f = hp ? {1'b1, pb, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < (hp ? 11 : 10); i++) begin
      rxd <= f[i];
      repeat (BIT_T) @(posedge sys_clk);
    end
  endtask
  // samples mid-bit; b[8] is parity or stop, b[9] stop or idle
  task automatic grab(output logic [9:0] b, output logic ok);
    int w;
    w = 0;
    while (txd !== 1'b0 && w < 200) begin
      @(posedge sys_clk);
      w++;
    end
    ok = (w < 200);
    repeat (BIT_T / 2) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_T) @(posedge sys_clk);
      b[i] = txd;
    end
  endtask
endmodule
`default_nettype wire

// *** uart_parity_gen_check_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_parity_gen_check_tb_top;
  typedef struct packed {
    logic [2:0] m;
    logic [7:0] d;
    logic tp;
    logic rp;
    logic er;
  } upgc_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic txd;
  logic rxd;
  logic irq;
  logic [31:0] q;
  logic [9:0] b;
  logic ok;
  int mismatches = 0;
  int cmp_count = 0;
  upgc_row_t rows [10] = '{
    '{upg_pkg::PAR_EVEN, 8'h41, 1'b0, 1'b1, 1'b1},
    '{upg_pkg::PAR_ODD, 8'h41, 1'b1, 1'b1, 1'b0},
    '{upg_pkg::PAR_MARK, 8'h41, 1'b1, 1'b0, 1'b1},
    '{upg_pkg::PAR_SPACE, 8'h41, 1'b0, 1'b1, 1'b1},
    '{upg_pkg::PAR_NONE, 8'h41, 1'b1, 1'b0, 1'b0},
    '{upg_pkg::PAR_EVEN, 8'hFF, 1'b0, 1'b0, 1'b0},
    '{upg_pkg::PAR_ODD, 8'h07, 1'b0, 1'b1, 1'b1},
    '{upg_pkg::PAR_MULTI, 8'h41, 1'b0, 1'b1, 1'b0},
    '{upg_pkg::PAR_SPACE, 8'h00, 1'b0, 1'b0, 1'b0},
    '{upg_pkg::PAR_MARK, 8'h00, 1'b1, 1'b1, 1'b0}};
  upg_top dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .irq(irq));
  upg_remote #(.BIT_T(4)) rem (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // bad even-parity frame of 0x41 carries parity 1; good one carries 0
  task automatic rx_frame(input logic pb);
    rem.send(8'h41, 1'b1, pb);
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, upg_pkg::OFS_MODE, 32'h0);
    chk_word(q, {29'h0, upg_pkg::MODE_RST});
    chk_bit(pslverr, 1'b0);
    apb(1'b0, upg_pkg::OFS_STAT, 32'h0);
    chk_bit(q[upg_pkg::ST_PERR_BIT], 1'b0);
    apb(1'b0, 8'h30, 32'h0);
    chk_word(q, 32'h0);
    apb(1'b1, upg_pkg::OFS_BAUD, 32'h3);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1'b1, upg_pkg::OFS_MODE, {29'h0, rows[i].m});
      apb(1'b1, upg_pkg::OFS_TXD, {24'h0, rows[i].d});
      rem.grab(b, ok);
      chk_bit(ok, 1'b1);
      chk_word({24'h0, b[7:0]}, {24'h0, rows[i].d});
      chk_bit(b[8], rows[i].tp);
      chk_bit(b[9], 1'b1);
      repeat (8) @(posedge sys_clk);
      rem.send(rows[i].d, rows[i].m != upg_pkg::PAR_NONE, rows[i].rp);
      repeat (12) @(posedge sys_clk);
      apb(1'b0, upg_pkg::OFS_STAT, 32'h0);
      chk_bit(q[upg_pkg::ST_PERR_BIT], rows[i].er);
      if (rows[i].m == upg_pkg::PAR_MULTI) begin
        chk_bit(q[upg_pkg::ST_ADDR_BIT], rows[i].rp);
      end
      apb(1'b0, upg_pkg::OFS_RXD, 32'h0);
      chk_word(q, {24'h0, rows[i].d});
      apb(1'b1, upg_pkg::OFS_CTRL, 32'h1);
      apb(1'b0, upg_pkg::OFS_STAT, 32'h0);
      chk_bit(q[upg_pkg::ST_PERR_BIT], 1'b0);
      $display("row %0d done", i);
    end
    apb(1'b1, upg_pkg::OFS_MODE, {29'h0, upg_pkg::PAR_EVEN});
    apb(1'b1, upg_pkg::OFS_IER, 32'h1);
    rx_frame(1'b1);
    chk_bit(irq, 1'b1);
    rx_frame(1'b0);
    apb(1'b1, upg_pkg::OFS_CTRL, 32'h0);
    apb(1'b0, upg_pkg::OFS_STAT, 32'h0);
    chk_bit(q[upg_pkg::ST_PERR_BIT], 1'b1);
    apb(1'b1, upg_pkg::OFS_ICR, 32'h1);
    chk_bit(irq, 1'b0);
    apb(1'b1, upg_pkg::OFS_IER, 32'h0);
    rx_frame(1'b1);
    chk_bit(irq, 1'b0);
    apb(1'b0, upg_pkg::OFS_STAT, 32'h0);
    chk_bit(q[upg_pkg::ST_PERR_BIT], 1'b1);
    $display("sticky and interrupt test done");
    // mid-run reset with the flag pending and its interrupt enabled
    apb(1'b1, upg_pkg::OFS_IER, 32'h1);
    chk_bit(irq, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_bit(irq, 1'b0);
    chk_bit(txd, 1'b1);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, upg_pkg::OFS_MODE, 32'h0);
    chk_word(q, {29'h0, upg_pkg::MODE_RST});
    apb(1'b0, upg_pkg::OFS_STAT, 32'h0);
    chk_bit(q[upg_pkg::ST_PERR_BIT], 1'b0);
    apb(1'b0, upg_pkg::OFS_BAUD, 32'h0);
    chk_word(q, {16'h0, upg_pkg::BAUD_RST});
    $display("mid-run reset test done");
    close_out;
  end
endmodule
`default_nettype wire
